// File: hdl/ccm_top.sv
module ccm_top
    import ccm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              in_valid,
    output wire logic              in_ready,
    input  wire logic [PIX_W-1:0]  in_pix,
    output wire logic              out_valid,
    input  wire logic              out_ready,
    output wire logic [PIX_W-1:0]  out_pix,
    input  wire logic              conv_en,
    input  wire logic [1:0]        set_sel,
    input  wire logic              cfg_we,
    input  wire logic [1:0]        cfg_set,
    input  wire logic [3:0]        cfg_idx,
    input  wire logic [COEF_W-1:0] cfg_wdata,
    input  wire logic              cfg_restore,
    output logic                   cfg_err
);
    logic [COEF_W-1:0] coef_r [NSET][NCOEF];
    logic [COEF_W-1:0] coef_nxt [NSET][NCOEF];
    logic [OFF_W-1:0]  off_r [NSET][NOFF];
    logic [OFF_W-1:0]  off_nxt [NSET][NOFF];
    logic              err_r, err_nxt;
    logic [PIX_W-1:0]  pix_r, pix_nxt;
    logic              v_r, v_nxt;
    logic [PIX_W-1:0]  sat_pix;
    logic signed [ACC_W-1:0] acc [3];

    ccm_stream_if #(.W(PIX_W)) fs ();

    ccm_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk  (clk),
        .srst (srst),
        .f    (fs.fifo)
    );

    assign fs.in_valid  = v_r;
    assign fs.in_data   = pix_r;
    assign fs.out_ready = out_ready;
    assign in_ready     = fs.in_ready;
    assign out_valid    = fs.out_valid;
    assign out_pix      = fs.out_data;
    assign cfg_err      = err_r;

    // Clamp a written gain to the +/-2.0 range
    function automatic logic [COEF_W-1:0] clamp_coef(input logic [COEF_W-1:0] v);
        if ($signed(v) > $signed(COEF_MAX))
            return COEF_MAX;
        else if ($signed(v) < $signed(COEF_MIN))
            return COEF_MIN;
        return v;
    endfunction

    // Clamp a written offset; -512 is not a legal offset
    function automatic logic [OFF_W-1:0] clamp_off(input logic [COEF_W-1:0] v);
        if ($signed(v) > $signed({2'b00, OFF_MAX}))
            return OFF_MAX;
        else if ($signed(v) < $signed({2'b11, OFF_MIN}))
            return OFF_MIN;
        return v[OFF_W-1:0];
    endfunction

    // Coefficient store next state; a reload beats a direct write
    always_comb
    begin
        coef_nxt = coef_r;
        off_nxt  = off_r;
        err_nxt  = 1'b0;
        if (cfg_restore)
        begin
            for (int s = 1; s < NSET; s++)
            begin
                for (int k = 0; k < NCOEF; k++)
                    coef_nxt[s][k] = (k % 4 == 0) ? COEF_ONE : COEF_ZERO;
                for (int k = 0; k < NOFF; k++)
                    off_nxt[s][k] = OFF_ZERO;
            end
        end
        else if (cfg_we)
        begin
            if (cfg_set == SET_FIXED || cfg_idx > IDX_LAST)
                err_nxt = 1'b1;
            else if (cfg_idx < IDX_OFF0)
                coef_nxt[cfg_set][cfg_idx] = clamp_coef(cfg_wdata);
            else
                off_nxt[cfg_set][2'(cfg_idx - IDX_OFF0)] = clamp_off(cfg_wdata);
        end
    end

    // Coefficient store registers; fixed set loaded only here
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            err_r <= 1'b0;
            for (int s = 0; s < NSET; s++)
            begin
                for (int k = 0; k < NCOEF; k++)
                    coef_r[s][k] <= (s == 0) ? FIXED_COEF[NCOEF-1-k]
                                  : ((k % 4 == 0) ? COEF_ONE : COEF_ZERO);
                for (int k = 0; k < NOFF; k++)
                    off_r[s][k] <= (s == 0) ? FIXED_OFF[NOFF-1-k] : OFF_ZERO;
            end
        end
        else
        begin
            err_r  <= err_nxt;
            coef_r <= coef_nxt;
            off_r  <= off_nxt;
        end
    end

    // One dot product per output channel, red in low bits
    for (genvar c = 0; c < 3; c++)
    begin : g_row
        logic signed [CORR_W-1:0] corr [3];
        logic signed [PROD_W-1:0] prod [3];
        for (genvar k = 0; k < 3; k++)
        begin : g_term
            assign corr[k] = $signed({2'b00, in_pix[k*SAMP_W +: SAMP_W]})
                           + $signed({{2{off_r[set_sel][k][OFF_W-1]}},
                                      off_r[set_sel][k]});
            assign prod[k] = corr[k] * $signed(coef_r[set_sel][c*3+k]);
        end
        assign acc[c] = ACC_W'(prod[0]) + ACC_W'(prod[1]) + ACC_W'(prod[2])
                      + $signed(ACC_RND);

        // Clip instead of wrap so bright pixels never turn dark
        always_comb
        begin
            if (acc[c] < 0)
                sat_pix[c*SAMP_W +: SAMP_W] = '0;
            else if ((acc[c] >>> COEF_FRAC) > $signed({16'h0000, SAMP_MAX}))
                sat_pix[c*SAMP_W +: SAMP_W] = SAMP_MAX;
            else
                sat_pix[c*SAMP_W +: SAMP_W] = acc[c][COEF_FRAC +: SAMP_W];
        end
    end

    // Pipeline stage; selector and enable taken with each pixel
    always_comb
    begin
        v_nxt   = in_valid && fs.in_ready;
        pix_nxt = pix_r;
        if (v_nxt)
            pix_nxt = conv_en ? sat_pix : in_pix;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            v_r   <= 1'b0;
            pix_r <= '0;
        end
        else
        begin
            v_r   <= v_nxt;
            pix_r <= pix_nxt;
        end
    end

    fixed_set_a: assert property (
        @(posedge clk) disable iff (srst)
        cfg_we && cfg_set == SET_FIXED && !cfg_restore
        |=> err_r && coef_r[0][0] == $past(coef_r[0][0]) && off_r[0][1] == $past(off_r[0][1]))
        else $error("fixed set write not rejected");

    gain_write_a: assert property (
        @(posedge clk) disable iff (srst)
        cfg_we && !cfg_restore && cfg_set != SET_FIXED && cfg_idx < IDX_OFF0
        && $signed(cfg_wdata) <= $signed(COEF_MAX) && $signed(cfg_wdata) >= $signed(COEF_MIN)
        |=> coef_r[$past(cfg_set)][$past(cfg_idx)] == $past(cfg_wdata))
        else $error("gain write not stored");

    reload_ident_a: assert property (
        @(posedge clk) disable iff (srst)
        cfg_restore |=> coef_r[1][0] == COEF_ONE && coef_r[2][1] == COEF_ZERO
                        && coef_r[3][8] == COEF_ONE && off_r[3][2] == OFF_ZERO && !err_r)
        else $error("reload did not restore identity");

    bypass_pass_a: assert property (
        @(posedge clk) disable iff (srst)
        in_valid && fs.in_ready && !conv_en |=> v_r && pix_r == $past(in_pix))
        else $error("bypass altered pixel");

    clip_low_a: assert property (
        @(posedge clk) disable iff (srst)
        v_nxt && conv_en && acc[1] < 0 |=> pix_r[2*SAMP_W-1:SAMP_W] == '0)
        else $error("negative result not clipped to zero");

    clip_high_a: assert property (
        @(posedge clk) disable iff (srst)
        v_nxt && conv_en && (acc[0] >>> COEF_FRAC) > $signed({16'h0000, SAMP_MAX})
        |=> pix_r[SAMP_W-1:0] == SAMP_MAX)
        else $error("high result not clipped to full scale");

    offset_range_a: assert property (
        @(posedge clk) disable iff (srst)
        off_r[1][0] != 10'h200 && off_r[2][2] != 10'h200)
        else $error("offset outside -511..+511");

    gain_range_a: assert property (
        @(posedge clk) disable iff (srst)
        $signed(coef_r[1][0]) <= $signed(COEF_MAX) && $signed(coef_r[1][4]) >= $signed(COEF_MIN))
        else $error("gain outside -2..+2");

    ident_path_a: assert property (
        @(posedge clk) disable iff (srst)
        v_nxt && conv_en && set_sel == 2'h1 && coef_r[1][0] == COEF_ONE
        && coef_r[1][1] == COEF_ZERO && coef_r[1][2] == COEF_ZERO && off_r[1][0] == OFF_ZERO
        |=> pix_r[SAMP_W-1:0] == $past(in_pix[SAMP_W-1:0]))
        else $error("unity row did not pass red through");
endmodule // ccm_top

// File: hdl/ccm_pkg.sv
package ccm_pkg;
    // Sample and coefficient formats, store sizes and FIFO depth
    localparam int SAMP_W    = 10;
    localparam int PIX_W     = 3 * SAMP_W;
    localparam int COEF_W    = 12;          // Signed, 9 fraction bits
    localparam int COEF_FRAC = 9;
    localparam int OFF_W     = 10;
    localparam int CORR_W    = 12;
    localparam int PROD_W    = CORR_W + COEF_W;
    localparam int ACC_W     = PROD_W + 2;
    localparam int NSET      = 4;
    localparam int NCOEF     = 9;
    localparam int NOFF      = 3;
    localparam int FIFO_DEPTH = 32;

    // Unit, zero, limit and rounding values
    localparam logic [COEF_W-1:0] COEF_ONE  = 12'h200;  // 1.0
    localparam logic [COEF_W-1:0] COEF_ZERO = 12'h000;
    localparam logic [COEF_W-1:0] COEF_MAX  = 12'h400;  // +2.0
    localparam logic [COEF_W-1:0] COEF_MIN  = 12'hC00;  // -2.0
    localparam logic [OFF_W-1:0]  OFF_ZERO  = 10'h000;
    localparam logic [OFF_W-1:0]  OFF_MAX   = 10'h1FF;  // +511
    localparam logic [OFF_W-1:0]  OFF_MIN   = 10'h201;  // -511
    localparam logic [SAMP_W-1:0] SAMP_MAX  = 10'h3FF;
    localparam logic [ACC_W-1:0]  ACC_RND   = 26'h0000100;

    // Write index map: gains 0..8 row-major, offsets 9..11 (R, G, B)
    localparam logic [3:0] IDX_OFF0 = 4'h9;
    localparam logic [3:0] IDX_LAST = 4'hB;
    localparam logic [1:0] SET_FIXED = 2'h0;

    // Fixed first set gains, row-major; replace with the factory colour-space gains
    localparam logic [NCOEF-1:0][COEF_W-1:0] FIXED_COEF = {
        12'h200, 12'h000, 12'h000,
        12'h000, 12'h200, 12'h000,
        12'h000, 12'h000, 12'h200};
    localparam logic [NOFF-1:0][OFF_W-1:0] FIXED_OFF = {10'h000, 10'h000, 10'h000};
endpackage

// File: hdl/ccm_stream_if.sv
// Pixel stream between datapath stage and output FIFO
interface ccm_stream_if #(parameter int W = 30);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport src  (output in_valid, input in_ready, output in_data,
                  input out_valid, output out_ready, input out_data);
    modport fifo (input in_valid, output in_ready, input in_data,
                  output out_valid, input out_ready, output out_data);
endinterface

// File: hdl/ccm_fifo.sv
module ccm_fifo #(
    parameter int W     = 30,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic srst,
    ccm_stream_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_SPACE = (AW+1)'(DEPTH - 2);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          space_r, space_nxt, valid_r, valid_nxt;
    logic          push, pop;

    // Ready only while two slots are free, so the stage before never stalls
    assign push = f.in_valid && (cnt_r != (AW+1)'(DEPTH));
    assign pop  = valid_r && f.out_ready;
    assign f.in_ready  = space_r;
    assign f.out_valid = valid_r;
    assign f.out_data  = mem[rd_r];

    // Pointer and count next state
    always_comb
    begin
        wr_nxt  = push ? wr_r + 1'b1 : wr_r;
        rd_nxt  = pop ? rd_r + 1'b1 : rd_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        space_nxt = cnt_nxt <= CNT_SPACE;
        valid_nxt = cnt_nxt != '0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_r    <= '0;
            rd_r    <= '0;
            cnt_r   <= '0;
            space_r <= 1'b0;
            valid_r <= 1'b0;
        end
        else
        begin
            wr_r    <= wr_nxt;
            rd_r    <= rd_nxt;
            cnt_r   <= cnt_nxt;
            space_r <= space_nxt;
            valid_r <= valid_nxt;
        end
    end

    // Storage has no reset; only written entries are ever read
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_r] <= f.in_data;
    end

    no_overflow_a: assert property (@(posedge clk) disable iff (srst)
        f.in_valid |-> cnt_r != (AW+1)'(DEPTH))
        else $error("push into full fifo");

    empty_flag_a: assert property (@(posedge clk) disable iff (srst)
        valid_r == (cnt_r != '0))
        else $error("fifo valid flag disagrees with count");
endmodule // ccm_fifo

// File: tb/ccm_pix_source.sv
// Upstream pixel chain: holds each pixel until taken
module ccm_pix_source
    import ccm_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             in_ready,
    output logic                  in_valid,
    output logic [PIX_W-1:0]      in_pix
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle at time zero
    initial
    begin
        in_valid = 1'b0;
        in_pix   = '0;
    end

    // Called at a falling edge; returns at the falling edge after the take
    task automatic send(input logic [PIX_W-1:0] p);
        int n;
        in_valid = 1'b1;
        in_pix   = p;
        n = 0;
        // Ready is registered, so its value here stands at the next rising edge
        while (in_ready !== 1'b1 && n < 200)
        begin
            n++;
            @(negedge clk);
        end
        @(negedge clk);
    endtask

    // Released bus never shows a stale pixel
    task automatic stop();
        in_valid = 1'b0;
        in_pix   = ~in_pix;
    endtask
endmodule // ccm_pix_source

// File: tb/ccm_top_test.sv
module ccm_top_test;
    import ccm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk, srst, in_valid, in_ready, out_valid, out_ready, conv_en;
    logic              cfg_we, cfg_restore, cfg_err;
    logic [1:0]        set_sel, cfg_set;
    logic [3:0]        cfg_idx;
    logic [COEF_W-1:0] cfg_wdata;
    logic [PIX_W-1:0]  in_pix, out_pix;
    int                errors, samples_checked, cyc, n;
    int                gn[NSET][NCOEF];
    int                off[NSET][NOFF];
    logic [PIX_W-1:0]  exp_q[$];
    // Writes as {set, index, value}; several lie out of range on purpose
    localparam logic [17:0] WTBL [8] = '{18'h107FF, 18'h14800, 18'h19E00, 18'h1B1FF,
                                         18'h21100, 18'h2A3FF, 18'h38C00, 18'h32401};
    localparam logic [PIX_W-1:0] P1 = {10'h3FF, 10'h3FF, 10'h3FF};
    localparam logic [PIX_W-1:0] P2 = {10'h010, 10'h200, 10'h000};

    ccm_top uut (.clk, .srst, .in_valid, .in_ready, .in_pix, .out_valid, .out_ready,
        .out_pix, .conv_en, .set_sel, .cfg_we, .cfg_set, .cfg_idx, .cfg_wdata,
        .cfg_restore, .cfg_err);
    ccm_pix_source src (.clk, .in_ready, .in_valid, .in_pix);

    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Reference transform in plain int, so saturation is seen
    function automatic logic [PIX_W-1:0] ref_pix(logic [PIX_W-1:0] p, int s, logic en);
        int               acc;
        logic [PIX_W-1:0] r;
        if (en !== 1'b1)
            return p;
        for (int c = 0; c < 3; c++)
        begin
            acc = 256;
            for (int k = 0; k < 3; k++)
                acc += (int'(p[k*SAMP_W+:SAMP_W]) + off[s][k]) * gn[s][c*3+k];
            acc = acc >>> COEF_FRAC;
            acc = acc < 0 ? 0 : (acc > 1023 ? 1023 : acc);
            r[c*SAMP_W+:SAMP_W] = acc[SAMP_W-1:0];
        end
        return r;
    endfunction

    // Model sets from the first given one upward to their start values
    task automatic model_init(int first);
        for (int s = first; s < NSET; s++)
            for (int i = 0; i < NCOEF + NOFF; i++)
                if (i < NCOEF)
                    gn[s][i] = s == 0 ? int'($signed(FIXED_COEF[NCOEF-1-i])) : (i % 4 == 0 ? 512 : 0);
                else
                    off[s][i-NCOEF] = s == 0 ? int'($signed(FIXED_OFF[NCOEF+NOFF-1-i])) : 0;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic px(logic [PIX_W-1:0] p, logic [1:0] s, logic en);
        set_sel = s;
        conv_en = en;
        exp_q.push_back(ref_pix(p, s, en));
        src.send(p);
    endtask

    task automatic drain();
        src.stop();
        for (int k = 0; k < 100 && exp_q.size() > 0; k++)
            @(negedge clk);
        chk(exp_q.size(), 0);
    endtask

    // One write, then count error pulses over the next three cycles
    task automatic wr(logic [1:0] s, logic [3:0] i, logic [11:0] d, logic rej);
        int v, e;
        cfg_we = 1'b1;
        cfg_set = s;
        cfg_idx = i;
        cfg_wdata = d;
        @(negedge clk);
        cfg_we = 1'b0;
        v = $signed(d);
        e = 0;
        repeat (3)
        begin
            e += (cfg_err === 1'b1);
            @(negedge clk);
        end
        chk(e, 32'(rej));
        if (!rej && i < IDX_OFF0)
            gn[s][i] = v > 1024 ? 1024 : (v < -1024 ? -1024 : v);
        else if (!rej)
            off[s][i-IDX_OFF0] = v > 511 ? 511 : (v < -511 ? -511 : v);
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Scoreboard on every accepted output beat
    always @(posedge clk)
        if (srst === 1'b0 && out_valid === 1'b1 && out_ready === 1'b1)
            chk(out_pix, exp_q.size() > 0 ? exp_q.pop_front() : ~out_pix);

    // Hang guard, far above the 150 or so cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    // Main sequence
    initial
    begin
        {srst, out_ready} = 2'b11;
        {conv_en, set_sel, cfg_we, cfg_set, cfg_idx, cfg_wdata, cfg_restore} = '0;
        model_init(0);
        repeat (6) @(negedge clk);
        chk({in_ready, out_valid, cfg_err}, 0);
        srst = 1'b0;
        for (int s = 0; s < NSET; s++)
            px(P2, s, 1'b1);
        drain();
        $display("start values done");
        foreach (WTBL[j])
            wr(WTBL[j][17:16], WTBL[j][15:12], WTBL[j][11:0], 1'b0);
        for (int s = 1; s < NSET; s++)
        begin
            px(P1, s, 1'b1);
            px(P2, s, 1'b1);
        end
        drain();
        $display("writes done");
        wr(2'h0, 4'h0, 12'h100, 1'b1);
        wr(2'h0, 4'hB, 12'h010, 1'b1);
        wr(2'h1, 4'hC, 12'h001, 1'b1);
        wr(2'h3, 4'hF, 12'h001, 1'b1);
        px(P1, 2'h0, 1'b1);
        px(P1, 2'h1, 1'b1);
        px(P2, 2'h1, 1'b0);
        px(P1, 2'h3, 1'b0);
        drain();
        $display("refusals and bypass done");
        cfg_restore = 1'b1;
        @(negedge clk);
        cfg_restore = 1'b0;
        model_init(1);
        for (int s = 1; s < NSET; s++)
            px(P2, s, 1'b1);
        drain();
        $display("restore done");
        out_ready = 1'b0;
        n = 0;
        while (in_ready === 1'b1 && n < 40)
        begin
            px(P2 + PIX_W'(n), 2'h2, 1'b1);
            n++;
        end
        src.stop();
        chk(n >= 30 && n <= 33, 1);
        out_ready = 1'b1;
        drain();
        $display("fifo fill done");
        give_verdict();
    end
endmodule // ccm_top_test
